// File: logic/sbsp_defines.vh
`ifndef SBSP_DEFINES_VH
`define SBSP_DEFINES_VH

// Snooze exit count in clock cycles, counted after the two-cycle sync delay
`define SBSP_SNOOZE_CYCLES 2'h2
// Burst order select level for interleaved order
`define SBSP_ORDER_INTERLEAVED 1'b1
// Reset value of the lane enables, all drivers off
`define SBSP_LANES_OFF 4'h0
// Depth of the write data FIFO
`define SBSP_FIFO_DEPTH 32
// Memory address width of the 36-bit version
`define SBSP_ADDR_WIDTH 19

`endif

// File: logic/sbsp_fifo.v
`timescale 1ns/1ns
`default_nettype none

// Write data FIFO between the pin capture and the storage array
module sbsp_fifo #(
  parameter WIDTH = 36,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             mclk,
  input  wire             reset_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;

  wire do_wr = in_valid & in_ready;
  wire do_rd = out_valid & out_ready;

  assign out_valid = (wr_ptr != rd_ptr);
  assign in_ready  = ((wr_ptr[AW] != rd_ptr[AW]) ? 1'b0 : 1'b1) |
                     (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_data  = mem[rd_ptr[AW-1:0]];

  always @(posedge mclk)
  begin
    if (do_wr)
      mem[wr_ptr[AW-1:0]] <= in_data;
  end

  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr <= wr_ptr + 1'b1;
      if (do_rd)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: logic/sbsp_port.v
// Notes on behaviour
// - Chip select high with controller status low: next cycle deselected, pins released one cycle after that.
// - Processor status low with chip select low loads address, starts a read.
// - Write when global write low, or qualifier low with any lane low.
// - Each lane strobe writes only its byte and parity bit.
// - Inputs registered on rising edge; output enable and snooze pass a two-flop synchroniser first.
// - Both status high, step high: repeat current address, read or write.
// - Both status high, step low: advance counter; order high gives interleaved.
// - Order select low gives linear burst order.
// - Data pins stay released from power-up until a read is issued.
// - Snooze stops sampling within two cycles, samples again on the sixth edge after release.
`timescale 1ns/1ns
`default_nettype none

`include "sbsp_defines.vh"

module sbsp_port #(
  parameter AW = `SBSP_ADDR_WIDTH
) (
  input  wire          mclk,
  input  wire          reset_n,
  input  wire          chip_select_n,
  input  wire          processor_addr_status_n,
  input  wire          controller_addr_status_n,
  input  wire          burst_step_n,
  input  wire          all_bytes_write_n,
  input  wire          byte_write_qualifier_n,
  input  wire [3:0]    lane_write_n,
  input  wire          output_enable_n,
  input  wire          snooze_request,
  input  wire          burst_order,
  input  wire [AW-1:0] address,
  input  wire [31:0]   data_lanes_in,
  input  wire [3:0]    parity_lanes_in,
  output reg  [31:0]   data_lanes_out,
  output reg  [3:0]    parity_lanes_out,
  output reg  [3:0]    lane_drive_en,
  output reg           write_stall
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers for the asynchronous inputs

  reg [1:0] oe_sync;
  reg [1:0] zz_sync;
  wire      oe_n_s = oe_sync[1];
  wire      zz_s   = zz_sync[1];

  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      oe_sync <= 2'h3;
      zz_sync <= 2'h0;
    end
    else
    begin
      oe_sync <= {oe_sync[0], output_enable_n};
      zz_sync <= {zz_sync[0], snooze_request};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Snooze sampling gate

  reg [1:0] zz_count;
  reg       sampling;

  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      zz_count <= 2'h0;
      sampling <= 1'b1;
    end
    else if (zz_s)
    begin
      zz_count <= 2'h0;
      sampling <= 1'b0;
    end
    else if (!sampling && zz_count != `SBSP_SNOOZE_CYCLES)
      zz_count <= zz_count + 2'h1;
    else if (!sampling)
      sampling <= 1'b1;
  end

  // Gate on the synchronised pin too, so entry costs only the sync delay
  wire taking = sampling & ~zz_s;

  ////////////////////////////////////////////////////////////////////
  // Cycle decode

  wire is_write = ~all_bytes_write_n |
                  (~byte_write_qualifier_n & ~(&lane_write_n));
  wire [3:0] lane_wr = all_bytes_write_n ?
                       (~lane_write_n & {4{~byte_write_qualifier_n}}) : 4'hf;

  wire deselect   = chip_select_n & ~controller_addr_status_n;
  wire start_proc = ~chip_select_n & ~processor_addr_status_n;
  wire start_ctrl = ~chip_select_n & processor_addr_status_n &
                    ~controller_addr_status_n;
  wire cont       = processor_addr_status_n & controller_addr_status_n |
                    chip_select_n & controller_addr_status_n;

  reg [AW-1:0] base_addr;
  reg [1:0]    step;
  reg          active;
  reg [AW-1:0] next_base_addr;
  reg [1:0]    next_step;
  reg          next_active;
  reg          do_read;
  reg          do_write;

  always @*
  begin
    next_base_addr = base_addr;
    next_step      = step;
    next_active    = active;
    do_read        = 1'b0;
    do_write       = 1'b0;
    if (taking)
    begin
      if (deselect)
        next_active = 1'b0;
      else if (start_proc)
      begin
        next_base_addr = address;
        next_step      = 2'h0;
        next_active    = 1'b1;
        do_read        = 1'b1;
      end
      else if (start_ctrl)
      begin
        next_base_addr = address;
        next_step      = 2'h0;
        next_active    = 1'b1;
        do_write       = is_write;
        do_read        = ~is_write;
      end
      else if (cont && active)
      begin
        if (!burst_step_n)
          next_step = step + 2'h1;
        do_write = is_write;
        do_read  = ~is_write;
      end
    end
  end

  // Interleaved xors the step in, linear adds it with wrap
  wire [1:0] low_bits = (burst_order == `SBSP_ORDER_INTERLEAVED) ?
                        (next_base_addr[1:0] ^ next_step) :
                        (next_base_addr[1:0] + next_step);
  wire [AW-1:0] eff_addr = {next_base_addr[AW-1:2], low_bits};

  ////////////////////////////////////////////////////////////////////
  // Storage with a write FIFO in front

  // Writes queue through the FIFO; reads bypass it, so software must not
  // read a word that is still queued. Trade-off for a single-port array.
  reg  [35:0] store [0:(1<<AW)-1];
  reg  [AW-1:0] wq_addr [0:`SBSP_FIFO_DEPTH-1];
  reg  [3:0]  wq_lanes [0:`SBSP_FIFO_DEPTH-1];
  reg  [4:0]  wq_wr;
  reg  [4:0]  wq_rd;
  wire        f_in_ready;
  wire        f_out_valid;
  wire [35:0] f_out_data;
  wire [35:0] f_in_data = {parity_lanes_in, data_lanes_in};
  wire        push = do_write & f_in_ready;
  wire        pop  = f_out_valid & ~do_read;

  sbsp_fifo #(
    .WIDTH (36),
    .DEPTH (`SBSP_FIFO_DEPTH),
    .AW    (5)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (do_write),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (pop),
    .out_data  (f_out_data)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_lane
      always @(posedge mclk)
      begin
        if (pop && wq_lanes[wq_rd][g])
        begin
          store[wq_addr[wq_rd]][8*g+7:8*g] <= f_out_data[8*g+7:8*g];
          store[wq_addr[wq_rd]][32+g]      <= f_out_data[32+g];
        end
      end
    end
  endgenerate

  always @(posedge mclk)
  begin
    if (push)
    begin
      wq_addr[wq_wr]  <= eff_addr;
      wq_lanes[wq_wr] <= lane_wr;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sequencing and output drive

  reg read_valid;

  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      base_addr        <= {AW{1'b0}};
      step             <= 2'h0;
      active           <= 1'b0;
      wq_wr            <= 5'h00;
      wq_rd            <= 5'h00;
      read_valid       <= 1'b0;
      data_lanes_out   <= 32'h00000000;
      parity_lanes_out <= 4'h0;
      lane_drive_en    <= `SBSP_LANES_OFF;
      write_stall      <= 1'b0;
    end
    else
    begin
      base_addr   <= next_base_addr;
      step        <= next_step;
      active      <= next_active;
      write_stall <= ~f_in_ready;
      if (push)
        wq_wr <= wq_wr + 5'h01;
      if (pop)
        wq_rd <= wq_rd + 5'h01;
      // Snoozed or deselected cycles carry no read, so the pins are released
      read_valid <= do_read;
      if (do_read)
        {parity_lanes_out, data_lanes_out} <= store[eff_addr];
      lane_drive_en <= {4{read_valid & ~oe_n_s}};
    end
  end

endmodule

`default_nettype wire

// File: testbench/sbsp_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module sbsp_port_monitor (
  input wire logic        mclk,
  input wire logic        reset_n,
  input wire logic        chip_select_n,
  input wire logic        processor_addr_status_n,
  input wire logic        controller_addr_status_n,
  input wire logic        all_bytes_write_n,
  input wire logic        byte_write_qualifier_n,
  input wire logic [3:0]  lane_write_n,
  input wire logic        output_enable_n,
  input wire logic        snooze_request,
  input wire logic [31:0] data_lanes_out,
  input wire logic [3:0]  lane_drive_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire ctl = !chip_select_n & processor_addr_status_n & !controller_addr_status_n;
  wire prc = !chip_select_n & !processor_addr_status_n;
  wire dsl = chip_select_n & !controller_addr_status_n;
  wire wq  = !all_bytes_write_n | (!byte_write_qualifier_n & ~&lane_write_n);
  // Snooze is folded in because a snoozed port ignores the command
  wire oe  = !output_enable_n & !snooze_request;
  ////////////////////////////////////////
  property p_reset_off;
    $rose(reset_n) |-> lane_drive_en == 4'h0 && data_lanes_out == 32'h0;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("drive on after reset");
  property p_oe_off;
    output_enable_n [*4] |-> lane_drive_en == 4'h0;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive with output disabled");
  property p_desel;
    dsl && !snooze_request |-> ##2 lane_drive_en == 4'h0;
  endproperty
  a_desel: assert property (p_desel) else $error("drive after deselect");
  property p_desel_hold;
    dsl && !snooze_request |-> ##1 $stable(data_lanes_out);
  endproperty
  a_desel_hold: assert property (p_desel_hold) else $error("data moved on deselect");
  property p_read;
    oe [*3] ##0 prc |-> ##2 lane_drive_en == 4'hf;
  endproperty
  a_read: assert property (p_read) else $error("no drive after read start");
  property p_start;
    oe [*3] ##0 ctl |-> ##2 lane_drive_en == ($past(wq, 2) ? 4'h0 : 4'hf);
  endproperty
  a_start: assert property (p_start) else $error("wrong kind of start");
  property p_write;
    ctl && wq |-> ##1 $stable(data_lanes_out) ##1 lane_drive_en == 4'h0;
  endproperty
  a_write: assert property (p_write) else $error("write drove data");
  property p_snooze;
    snooze_request [*6] ##0 prc |-> ##3 lane_drive_en == 4'h0;
  endproperty
  a_snooze: assert property (p_snooze) else $error("read taken in snooze");
endmodule
bind sbsp_port sbsp_port_monitor i_mon (
  .mclk                     (mclk),
  .reset_n                  (reset_n),
  .chip_select_n            (chip_select_n),
  .processor_addr_status_n  (processor_addr_status_n),
  .controller_addr_status_n (controller_addr_status_n),
  .all_bytes_write_n        (all_bytes_write_n),
  .byte_write_qualifier_n   (byte_write_qualifier_n),
  .lane_write_n             (lane_write_n),
  .output_enable_n          (output_enable_n),
  .snooze_request           (snooze_request),
  .data_lanes_out           (data_lanes_out),
  .lane_drive_en            (lane_drive_en)
);
`default_nettype wire

// File: testbench/sbsp_host.sv
`timescale 1ns/1ns
`default_nettype none
module sbsp_host (
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic writing,
  input  wire logic order_pick,
  output var  logic output_enable_n = 1'b1,
  output var  logic burst_order = 1'b1
);
  // Order pin only moves under reset, so the port never sees it change mid-run
  always @(posedge mclk)
  begin
    if (!reset_n)
      burst_order <= order_pick;
    output_enable_n <= writing;
  end
endmodule
`default_nettype wire

// File: testbench/sync_burst_sram_port_test.sv
`timescale 1ns/1ns
`default_nettype none
module sync_burst_sram_port_test;
  logic        mclk = 1'b0, reset_n = 1'b0, writing = 1'b0, order_pick = 1'b1;
  logic        chip_select_n = 1'b1, processor_addr_status_n = 1'b1;
  logic        controller_addr_status_n = 1'b1, burst_step_n = 1'b1;
  logic        all_bytes_write_n = 1'b1, byte_write_qualifier_n = 1'b1;
  logic        snooze_request = 1'b0, rd_q = 1'b0, v1 = 1'b0, v2 = 1'b0;
  logic [3:0]  lane_write_n = 4'hf, parity_lanes_in = 4'h0;
  logic [1:0]  cnt;
  logic [18:0] address = 19'h0;
  logic [31:0] data_lanes_in = 32'h0, lfsr = 32'he9ccc436;
  logic [35:0] mem [0:3];
  logic [35:0] exp_q [$];
  wire  [3:0]  lane_drive_en, parity_lanes_out;
  wire  [31:0] data_lanes_out;
  wire         output_enable_n, burst_order, write_stall;
  int          mismatches = 0, checked = 0;
  initial forever #5 mclk = ~mclk;
  sbsp_port i_dut (.*);
  sbsp_host i_host (.*);
  ////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] s);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic op(input logic [3:0] k, input logic [5:0] w, input logic [1:0] a, input logic r);
    @(negedge mclk);
    {chip_select_n, processor_addr_status_n, controller_addr_status_n, burst_step_n} = k;
    {all_bytes_write_n, byte_write_qualifier_n, lane_write_n} = w;
    address = {17'h0, a};
    rd_q = r;
    lfsr = nxt(lfsr);
    {parity_lanes_in, data_lanes_in} = {lfsr[3:0], lfsr};
  endtask
  // Idle is a deselect, which also ends any open burst
  task automatic idle(input int n);
    repeat (n) op(4'b1101, 6'h3f, 2'h0, 1'b0);
  endtask
  task automatic wr(input logic [1:0] a, input logic [5:0] w);
    op(4'b0101, w, a, 1'b0);
    for (int g = 0; g < 4; g++)
      if (!w[5] || (!w[4] && !w[g]))
      begin
        mem[a][8*g +: 8] = data_lanes_in[8*g +: 8];
        mem[a][32+g] = parity_lanes_in[g];
      end
  endtask
  task automatic rd(input logic [3:0] k, input logic [5:0] w, input logic [1:0] a, input logic [1:0] i);
    op(k, w, a, 1'b1);
    exp_q.push_back(mem[i]);
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(posedge mclk)
  begin
    v1 <= rd_q;
    v2 <= v1;
  end
  // Data stands from the edge that takes the read, drive one edge later
  always @(negedge mclk)
  begin
    if (v1 === 1'b1)
      chk("read", exp_q.size() ? exp_q.pop_front() : 36'hx, {parity_lanes_out, data_lanes_out});
    if (v2 === 1'b1)
      chk("drive", 36'hf, {32'h0, lane_drive_en});
  end
  initial
  begin
    for (int m = 1; m >= 0; m--)
    begin
      @(negedge mclk);
      reset_n = 1'b0;
      snooze_request = 1'b0;
      order_pick = m[0];
      repeat (6) @(negedge mclk);
      reset_n = 1'b1;
      writing = 1'b1;
      idle(2);
      for (int a = 0; a < 4; a++)
        wr(a[1:0], 6'h1f);
      wr(2'h1, 6'h2d);
      // Processor start reads; the global write comes on the next edge
      op(4'b0011, 6'h3f, 2'h3, 1'b0);
      op(4'b1111, 6'h1f, 2'h0, 1'b0);
      mem[3] = {parity_lanes_in, data_lanes_in};
      // Reads bypass the write queue, so let it drain first
      idle(8);
      writing = 1'b0;
      idle(3);
      rd(4'b0101, 6'h30, 2'h2, 2'h2);
      rd(4'b0011, 6'h1f, 2'h1, 2'h1);
      cnt = 2'h0;
      for (int c = 0; c < 4; c++)
      begin
        cnt = cnt + 2'(c != 1);
        rd({3'b111, c == 1}, 6'h3f, 2'h0, m ? 2'h1 ^ cnt : 2'h1 + cnt);
      end
      op(4'b1001, 6'h3f, 2'h0, 1'b0);
      idle(4);
      chk("stall", 36'h0, {35'h0, write_stall});
      chk("drive off", 36'h0, {32'h0, lane_drive_en});
      snooze_request = 1'b1;
      repeat (10) op(4'b0011, 6'h3f, 2'h0, 1'b0);
    end
    chk("pending", 36'h0, 36'(exp_q.size()));
    summarize();
  end
endmodule
`default_nettype wire
